// ---- src/mps_pkg.sv ----
// constants, states and timing shared by both ends of the power control link
//
// Overview of operation
// - Start on its own once supplies present
// - Power good high, operational after 5 s
// - PSM timer expiry: off until scheduled wake
// - Host holds wake high at least 5 s
// - Host polls power good to detect sleep
// - Forced off low holds device in reset
// - Forced off release turns off without detach
// - Host holds forced off low 200 ms
// - Device sequences own reset at start-up
// - Forced off toggling ignored during PSM
// - Forced off acts only while power good
// - Forced off line pulled up internally
// - Host drives forced off open collector only
// - Host uses forced off only when stuck
// - Normal turn-off takes over 1 s
// - Configured input falling edge starts fast power-down
// - Command also starts fast power-down
// - Device is SPI master: clock, MOSI, select
// - SPI and auxiliary UART never both enabled
// - Host grounds USB sense before PSM
// - Host keeps inputs low while device off
// - Power good off in deep sleep
package mps_pkg;

    localparam int unsigned CLK_KHZ        = 250_000;
    localparam int unsigned PWR_GOOD_MS    = 5000;
    localparam int unsigned WAKE_MIN_MS    = 5000;
    localparam int unsigned FORCE_MIN_MS   = 200;
    localparam int unsigned DETACH_MIN_MS  = 1000;
    localparam int unsigned BOOT_RESET_MS  = 10;
    localparam int unsigned PWR_GOOD_CYC   = PWR_GOOD_MS * CLK_KHZ;
    localparam int unsigned WAKE_MIN_CYC   = WAKE_MIN_MS * CLK_KHZ;
    localparam int unsigned FORCE_MIN_CYC  = FORCE_MIN_MS * CLK_KHZ;
    localparam int unsigned DETACH_MIN_CYC = DETACH_MIN_MS * CLK_KHZ;
    localparam int unsigned BOOT_RESET_CYC = BOOT_RESET_MS * CLK_KHZ;
    localparam int unsigned SPI_DIV_CYC    = 4;
    localparam int unsigned SPI_BITS       = 8;
    localparam int unsigned CNT_W          = 32;
    localparam logic [31:0] CNT_ZERO       = 32'h0000_0000;
    localparam logic [31:0] CNT_ONE        = 32'h0000_0001;

    typedef enum logic [7:0] {
        MPS_OFF    = 8'h01,
        MPS_BOOT   = 8'h02,
        MPS_UP     = 8'h04,
        MPS_READY  = 8'h08,
        MPS_HALT   = 8'h10,
        MPS_DETACH = 8'h20,
        MPS_SLEEP  = 8'h40
    } mps_state_t;

endpackage

// ---- src/mps_link_if.sv ----
// pin-level link between the module end and the host end
`timescale 1ns/1ps
interface mps_link_if;
    logic power_good_output;
    logic forced_off_o;
    logic forced_off_oe_n;
    logic forced_off_n;
    logic wake;
    logic usb_supply_sense;
    logic gpio_fpd;
    logic spi_clk;
    logic spi_cs_n;
    logic shared_tx;
    logic shared_rx;

    // internal pull-up: an undriven line reads inactive
    // pull-up resolution
    assign forced_off_n = forced_off_oe_n ? 1'b1 : forced_off_o;

    modport device (
        output power_good_output,
        input  forced_off_n,
        input  wake,
        input  usb_supply_sense,
        input  gpio_fpd,
        output spi_clk,
        output spi_cs_n,
        output shared_tx,
        input  shared_rx
    );

    modport host (
        input  power_good_output,
        output forced_off_o,
        output forced_off_oe_n,
        output wake,
        output usb_supply_sense,
        output gpio_fpd,
        input  spi_clk,
        input  spi_cs_n,
        input  shared_tx,
        output shared_rx
    );
endinterface

// ---- src/mps_device.sv ----
// module end: power sequencing, forced off, fast power-down, SPI/aux UART pins
`timescale 1ns/1ps
module mps_device
    import mps_pkg::*;
#(
    parameter int unsigned PWR_GOOD_CYCLES   = PWR_GOOD_CYC,
    parameter int unsigned WAKE_MIN_CYCLES   = WAKE_MIN_CYC,
    parameter int unsigned DETACH_MIN_CYCLES = DETACH_MIN_CYC,
    parameter int unsigned BOOT_RESET_CYCLES = BOOT_RESET_CYC,
    parameter int unsigned SPI_DIV           = SPI_DIV_CYC
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // link pins
    mps_link_if.device       link,
    // supplies
    input  wire logic        main_supply_in,
    input  wire logic        amplifier_supply_in,
    // power commands
    input  wire logic        psm_enable_in,
    input  wire logic        psm_timer_expired_in,
    input  wire logic        scheduled_wake_in,
    input  wire logic        turn_off_cmd_in,
    input  wire logic        detach_done_in,
    input  wire logic        fast_pd_cmd_in,
    input  wire logic        gpio_fpd_enable_in,
    // port selection and data
    input  wire logic        spi_select_in,
    input  wire logic        spi_start_in,
    input  wire logic [7:0]  spi_tx_data_in,
    input  wire logic        aux_tx_in,
    // status
    output logic             core_reset_out,
    output logic             operational_out,
    output logic [7:0]       state_out,
    output logic             spi_busy_out,
    output logic [7:0]       spi_rx_data_out,
    output logic             spi_rx_valid_out,
    output logic             aux_rx_out
);

    mps_state_t       state;
    mps_state_t       next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] wake_cnt;
    logic             supplies_prev;
    logic             gpio_prev;
    logic             power_good;

    wire supplies_ok  = main_supply_in & amplifier_supply_in;
    wire supplies_new = supplies_ok & ~supplies_prev;
    wire gpio_fall    = gpio_fpd_enable_in & gpio_prev & ~link.gpio_fpd;
    wire fast_pd      = gpio_fall | fast_pd_cmd_in;
    wire force_active = power_good & ~link.forced_off_n;
    wire boot_done    = cnt >= CNT_W'(BOOT_RESET_CYCLES - 1);
    wire pg_done      = cnt >= CNT_W'(PWR_GOOD_CYCLES - 1);
    wire detach_ok    = (cnt >= CNT_W'(DETACH_MIN_CYCLES - 1)) & detach_done_in;
    wire wake_long    = link.wake & (wake_cnt >= CNT_W'(WAKE_MIN_CYCLES - 1));
    wire in_running   = (state == MPS_UP) | (state == MPS_READY) | (state == MPS_DETACH);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        case (state)
            MPS_OFF: begin
                if (supplies_new) begin
                    next_state = MPS_BOOT;
                end
            end
            MPS_BOOT: begin
                if (boot_done) begin
                    next_state = MPS_UP;
                end
            end
            MPS_UP: begin
                if (pg_done) begin
                    next_state = MPS_READY;
                end
            end
            MPS_READY: begin
                if (psm_enable_in && psm_timer_expired_in) begin
                    next_state = MPS_SLEEP;
                end else if (turn_off_cmd_in) begin
                    next_state = MPS_DETACH;
                end
            end
            MPS_DETACH: begin
                if (detach_ok) begin
                    next_state = MPS_OFF;
                end
            end
            MPS_HALT: begin
                if (link.forced_off_n) begin
                    next_state = MPS_OFF;
                end
            end
            MPS_SLEEP: begin
                if (scheduled_wake_in || wake_long) begin
                    next_state = MPS_BOOT;
                end
            end
            default: begin
                next_state = MPS_OFF;
            end
        endcase
        // forced off and fast power-down override any running state
        if (in_running && force_active) begin
            next_state = MPS_HALT;
        end else if (in_running && fast_pd) begin
            next_state = MPS_OFF;
        end
        if (!supplies_ok) begin
            next_state = MPS_OFF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state         <= MPS_OFF;
            cnt           <= CNT_ZERO;
            supplies_prev <= 1'b0;
            gpio_prev     <= 1'b0;
        end else begin
            state         <= next_state;
            cnt           <= (next_state != state) ? CNT_ZERO : cnt + CNT_ONE;
            supplies_prev <= supplies_ok;
            gpio_prev     <= link.gpio_fpd;
        end
    end

    // wake hold counter restarts whenever the line drops
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_cnt <= CNT_ZERO;
        end else if (state == MPS_SLEEP && link.wake) begin
            wake_cnt <= wake_long ? wake_cnt : wake_cnt + CNT_ONE;
        end else begin
            wake_cnt <= CNT_ZERO;
        end
    end

    // power good registered; low in off, boot, halt and sleep
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            power_good      <= 1'b0;
            operational_out <= 1'b0;
            core_reset_out  <= 1'b1;
        end else begin
            power_good      <= (next_state == MPS_UP) | (next_state == MPS_READY) | (next_state == MPS_DETACH);
            operational_out <= next_state == MPS_READY;
            core_reset_out  <= ~((next_state == MPS_UP) | (next_state == MPS_READY) | (next_state == MPS_DETACH));
        end
    end

    assign link.power_good_output = power_good;
    assign state_out              = state;

    ////////////////////////////////////////////////////////////////////////
    // SPI master, mode 0, MSB first; runs only while operational
    logic [CNT_W-1:0] div_cnt;
    logic [7:0]       shift_tx;
    logic [7:0]       shift_rx;
    logic [3:0]       bit_cnt;
    logic             sclk;
    logic             busy;

    wire div_tick  = div_cnt >= CNT_W'(SPI_DIV - 1);
    wire spi_go    = spi_select_in & spi_start_in & ~busy & (state == MPS_READY);
    wire last_fall = div_tick & sclk & (bit_cnt == 4'(SPI_BITS - 1));

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_cnt <= CNT_ZERO;
            sclk    <= 1'b0;
            busy    <= 1'b0;
            bit_cnt <= 4'h0;
        end else if (spi_go) begin
            div_cnt <= CNT_ZERO;
            sclk    <= 1'b0;
            busy    <= 1'b1;
            bit_cnt <= 4'h0;
        end else if (busy && state != MPS_READY) begin
            busy <= 1'b0;
            sclk <= 1'b0;
        end else if (busy) begin
            div_cnt <= div_tick ? CNT_ZERO : div_cnt + CNT_ONE;
            if (div_tick) begin
                sclk    <= ~sclk;
                bit_cnt <= sclk ? bit_cnt + 4'h1 : bit_cnt;
                busy    <= ~last_fall;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_tx         <= 8'h00;
            shift_rx         <= 8'h00;
            spi_rx_data_out  <= 8'h00;
            spi_rx_valid_out <= 1'b0;
        end else begin
            spi_rx_valid_out <= busy & last_fall;
            if (spi_go) begin
                shift_tx <= spi_tx_data_in;
            end else if (busy && div_tick && !sclk) begin
                shift_rx <= {shift_rx[6:0], link.shared_rx};
            end else if (busy && div_tick && sclk) begin
                shift_tx <= {shift_tx[6:0], 1'b0};
            end
            if (busy && last_fall) begin
                spi_rx_data_out <= shift_rx;
            end
        end
    end

    // one function owns the shared pins
    wire spi_owns = spi_select_in;
    wire uart_owns = ~spi_select_in & (state == MPS_READY);

    assign link.spi_clk   = spi_owns & sclk;
    assign link.spi_cs_n  = ~(spi_owns & busy);
    assign link.shared_tx = spi_owns ? shift_tx[7] : (uart_owns ? aux_tx_in : 1'b1);
    assign aux_rx_out     = uart_owns ? link.shared_rx : 1'b1;
    assign spi_busy_out   = busy;

endmodule

// ---- src/mps_host.sv ----
// host end: wake pulse, open-collector forced off, USB sense and input gating
`timescale 1ns/1ps
module mps_host
    import mps_pkg::*;
#(
    parameter int unsigned WAKE_HOLD_CYCLES  = WAKE_MIN_CYC,
    parameter int unsigned FORCE_HOLD_CYCLES = FORCE_MIN_CYC
) (
    // clock and reset
    input  wire logic  clk_in,
    input  wire logic  rstn_in,
    // link pins
    mps_link_if.host   link,
    // requests
    input  wire logic  wake_req_in,
    input  wire logic  force_off_req_in,
    input  wire logic  psm_prepare_in,
    input  wire logic  usb_present_in,
    input  wire logic  gpio_fpd_in,
    input  wire logic  aux_tx_in,
    // status
    output logic       device_asleep_out,
    output logic       wake_busy_out,
    output logic       force_busy_out
);

    logic [CNT_W-1:0] wake_cnt;
    logic [CNT_W-1:0] force_cnt;
    logic             wake_drv;
    logic             force_drv;

    wire wake_end  = wake_cnt >= CNT_W'(WAKE_HOLD_CYCLES - 1);
    wire force_end = force_cnt >= CNT_W'(FORCE_HOLD_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_drv <= 1'b0;
            wake_cnt <= CNT_ZERO;
        end else if (!wake_drv) begin
            wake_drv <= wake_req_in & ~link.power_good_output;
            wake_cnt <= CNT_ZERO;
        end else begin
            wake_drv <= ~wake_end;
            wake_cnt <= wake_cnt + CNT_ONE;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            force_drv <= 1'b0;
            force_cnt <= CNT_ZERO;
        end else if (!force_drv) begin
            force_drv <= force_off_req_in & link.power_good_output;
            force_cnt <= CNT_ZERO;
        end else begin
            force_drv <= ~force_end;
            force_cnt <= force_cnt + CNT_ONE;
        end
    end

    // open collector: drive low or float
    assign link.forced_off_o    = 1'b0;
    assign link.forced_off_oe_n = ~force_drv;
    assign link.wake            = wake_drv;
    assign link.usb_supply_sense = usb_present_in & ~psm_prepare_in & link.power_good_output;
    assign link.gpio_fpd        = gpio_fpd_in & link.power_good_output;
    assign link.shared_rx       = aux_tx_in & link.power_good_output;
    assign device_asleep_out    = ~link.power_good_output;
    assign wake_busy_out        = wake_drv;
    assign force_busy_out       = force_drv;

endmodule

// ---- verif/mps_link_props.sv ----
// assertions on the pins between the module end and the host end
`timescale 1ns/1ps
module mps_link_props #(
    parameter int unsigned WAKE_HOLD_CYCLES  = 40,
    parameter int unsigned FORCE_HOLD_CYCLES = 20
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // link pins
    input wire logic power_good_output,
    input wire logic forced_off_o,
    input wire logic forced_off_oe_n,
    input wire logic forced_off_n,
    input wire logic wake,
    input wire logic usb_supply_sense,
    input wire logic gpio_fpd,
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic shared_tx,
    input wire logic shared_rx
);
    // wake hold plus boot is short, so a late power good is a hang
    localparam int WAKE_BOOT_MAX = 60;

    logic [31:0] wake_cnt;
    logic [31:0] low_cnt;
    logic [3:0]  sclk_rises;
    logic        sclk_prev;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_cnt   <= 32'h0;
            low_cnt    <= 32'h0;
            sclk_prev  <= 1'b0;
            sclk_rises <= 4'h0;
        end else begin
            wake_cnt   <= wake ? wake_cnt + 32'h1 : 32'h0;
            low_cnt    <= forced_off_n ? 32'h0 : low_cnt + 32'h1;
            sclk_prev  <= spi_clk;
            sclk_rises <= spi_cs_n ? 4'h0 : sclk_rises + {3'h0, spi_clk & ~sclk_prev};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_forced_low_seen;
        power_good_output && !forced_off_n;
    endsequence
    sequence s_frame_end;
        $rose(spi_cs_n);
    endsequence

    a_wake_hold_min: assert property ($fell(wake) |-> wake_cnt >= WAKE_HOLD_CYCLES - 1)
        else $error("wake released too early");
    a_force_hold_min: assert property ($rose(forced_off_n) |-> low_cnt >= FORCE_HOLD_CYCLES - 1)
        else $error("forced off released too early");
    a_open_collector_only: assert property (!forced_off_oe_n |-> forced_off_o == 1'b0)
        else $error("forced off driven high");
    a_force_halts_device: assert property (s_forced_low_seen |=> !power_good_output)
        else $error("forced off did not halt");
    a_no_restart_after: assert property ($rose(forced_off_n) && !power_good_output |=> !power_good_output [*8])
        else $error("device restarted after forced off");
    a_spi_eight_clocks: assert property (s_frame_end |-> sclk_rises == 4'h8)
        else $error("spi frame without eight clocks");
    a_spi_idle_clock: assert property (spi_cs_n |-> !spi_clk)
        else $error("spi clock moves while deselected");
    a_wake_boots_device: assert property ($rose(wake) && !power_good_output |-> ##[1:WAKE_BOOT_MAX] power_good_output)
        else $error("wake did not restart device");
    a_inputs_low_off: assert property (!power_good_output && !$past(power_good_output)
        |-> !usb_supply_sense && !gpio_fpd && !shared_rx)
        else $error("input driven high while device off");
endmodule

// ---- verif/module_power_control_sequencer_test.sv ----
// self-checking bench joining the module end and the host end
`timescale 1ns/1ps
module module_power_control_sequencer_test;
    import mps_pkg::*;
    localparam int unsigned PG_CYC  = 50;
    localparam int unsigned DET_CYC = 30;
    localparam int unsigned WK_HOLD = 40;
    localparam int unsigned FO_HOLD = 20;

    logic       clk_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       main_sup = 1'b0, amp_sup = 1'b0, psm_en = 1'b0, psm_exp = 1'b0, sched_wake = 1'b0;
    logic       off_cmd = 1'b0, det_done = 1'b0, fpd_cmd = 1'b0, fpd_en = 1'b0, spi_sel = 1'b0;
    logic       spi_go = 1'b0, dev_aux_tx = 1'b1, wake_req = 1'b0, force_req = 1'b0, psm_prep = 1'b0;
    logic       usb_pres = 1'b0, host_gpio = 1'b0, host_aux_tx = 1'b0;
    logic [7:0] spi_tx = 8'h00;
    logic       core_reset, operational, spi_busy, rx_valid, aux_rx, asleep, force_busy, wake_busy;
    logic [7:0] state, rx_data;
    int         n_mismatch = 0;
    int         comparisons = 0;

    mps_link_if link ();

    mps_device #(.PWR_GOOD_CYCLES(PG_CYC), .WAKE_MIN_CYCLES(30), .DETACH_MIN_CYCLES(DET_CYC),
        .BOOT_RESET_CYCLES(10), .SPI_DIV(4)) mps_device_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .link(link), .main_supply_in(main_sup),
        .amplifier_supply_in(amp_sup), .psm_enable_in(psm_en), .psm_timer_expired_in(psm_exp),
        .scheduled_wake_in(sched_wake), .turn_off_cmd_in(off_cmd), .detach_done_in(det_done),
        .fast_pd_cmd_in(fpd_cmd), .gpio_fpd_enable_in(fpd_en), .spi_select_in(spi_sel),
        .spi_start_in(spi_go), .spi_tx_data_in(spi_tx), .aux_tx_in(dev_aux_tx),
        .core_reset_out(core_reset), .operational_out(operational), .state_out(state),
        .spi_busy_out(spi_busy), .spi_rx_data_out(rx_data), .spi_rx_valid_out(rx_valid), .aux_rx_out(aux_rx));

    mps_host #(.WAKE_HOLD_CYCLES(WK_HOLD), .FORCE_HOLD_CYCLES(FO_HOLD)) mps_host_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .link(link), .wake_req_in(wake_req),
        .force_off_req_in(force_req), .psm_prepare_in(psm_prep), .usb_present_in(usb_pres),
        .gpio_fpd_in(host_gpio), .aux_tx_in(host_aux_tx), .device_asleep_out(asleep),
        .wake_busy_out(wake_busy), .force_busy_out(force_busy));

    mps_link_props #(.WAKE_HOLD_CYCLES(WK_HOLD), .FORCE_HOLD_CYCLES(FO_HOLD)) mps_link_props_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .power_good_output(link.power_good_output),
        .forced_off_o(link.forced_off_o), .forced_off_oe_n(link.forced_off_oe_n),
        .forced_off_n(link.forced_off_n), .wake(link.wake), .usb_supply_sense(link.usb_supply_sense),
        .gpio_fpd(link.gpio_fpd), .spi_clk(link.spi_clk), .spi_cs_n(link.spi_cs_n),
        .shared_tx(link.shared_tx), .shared_rx(link.shared_rx));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk_in = ~clk_in;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t ns: %s", $time, msg);
        end
    endtask

    task automatic wait_state(input logic [7:0] s, input int n);
        for (int i = 0; i < n && state !== s; i++) cyc(1);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic power_up;
        main_sup = 1'b0;
        amp_sup = 1'b0;
        cyc(3);
        main_sup = 1'b1;
        amp_sup = 1'b1;
        cyc(5);
        check(core_reset === 1'b1 && link.power_good_output === 1'b0, "boot reset");
        wait_state(MPS_UP, 20);
        check(link.power_good_output === 1'b1 && operational === 1'b0, "power good");
        cyc(PG_CYC - 5);
        check(operational === 1'b0, "operational too early");
        wait_state(MPS_READY, 10);
        check(operational === 1'b1 && core_reset === 1'b0, "operational");
    endtask

    task automatic t_spi;
        logic [7:0] mosi;
        host_aux_tx = 1'b1;
        spi_sel = 1'b1;
        spi_tx = 8'hA5;
        cyc(2);
        spi_go = 1'b1;
        cyc(1);
        spi_go = 1'b0;
        check(spi_busy === 1'b1 && link.spi_cs_n === 1'b0, "spi started");
        for (int b = 7; b >= 0; b--) begin
            @(posedge link.spi_clk);
            mosi[b] = link.shared_tx;
        end
        for (int i = 0; i < 40 && rx_valid !== 1'b1; i++) cyc(1);
        check(mosi === 8'hA5 && rx_data === 8'hFF && link.spi_cs_n === 1'b1 && spi_busy === 1'b0, "spi byte");
        spi_sel = 1'b0;
        dev_aux_tx = 1'b0;
        host_aux_tx = 1'b0;
        cyc(3);
        check(link.shared_tx === 1'b0 && aux_rx === 1'b0, "aux low");
        dev_aux_tx = 1'b1;
        host_aux_tx = 1'b1;
        spi_go = 1'b1;
        cyc(1);
        spi_go = 1'b0;
        cyc(3);
        check(link.shared_tx === 1'b1 && aux_rx === 1'b1 && link.spi_cs_n === 1'b1, "aux owns pins");
        host_aux_tx = 1'b0;
    endtask

    task automatic t_turn_off;
        det_done = 1'b1;
        off_cmd = 1'b1;
        cyc(1);
        off_cmd = 1'b0;
        cyc(DET_CYC - 5);
        check(state === MPS_DETACH && link.power_good_output === 1'b1, "detach holds");
        wait_state(MPS_OFF, 15);
        check(state === MPS_OFF && link.power_good_output === 1'b0, "turn off");
    endtask

    task automatic t_fast_pd;
        for (int k = 0; k < 2; k++) begin
            power_up();
            host_gpio = 1'b1;
            cyc(3);
            if (k == 0) begin
                host_gpio = 1'b0;
                cyc(4);
                check(state === MPS_READY, "fast power-down disabled");
                host_gpio = 1'b1;
                fpd_en = 1'b1;
                cyc(3);
                host_gpio = 1'b0;
            end else begin
                fpd_cmd = 1'b1;
            end
            cyc(1);
            fpd_cmd = 1'b0;
            cyc(3);
            check(state === MPS_OFF && link.power_good_output === 1'b0, "fast power-down");
        end
        host_gpio = 1'b0;
        fpd_en = 1'b0;
    endtask

    task automatic t_force;
        power_up();
        force_req = 1'b1;
        cyc(1);
        force_req = 1'b0;
        cyc(3);
        check(state === MPS_HALT && core_reset === 1'b1 && link.power_good_output === 1'b0, "halt");
        for (int i = 0; i < 60 && force_busy !== 1'b0; i++) cyc(1);
        cyc(3);
        check(state === MPS_OFF, "forced off");
        cyc(10);
        check(state === MPS_OFF && link.power_good_output === 1'b0, "stays off");
        force_req = 1'b1;
        cyc(1);
        force_req = 1'b0;
        cyc(5);
        check(link.forced_off_n === 1'b1 && state === MPS_OFF, "refused while off");
    endtask

    task automatic t_psm;
        power_up();
        usb_pres = 1'b1;
        cyc(3);
        check(link.usb_supply_sense === 1'b1, "usb sensed");
        psm_prep = 1'b1;
        cyc(3);
        check(link.usb_supply_sense === 1'b0, "usb grounded");
        psm_en = 1'b1;
        psm_exp = 1'b1;
        cyc(1);
        psm_exp = 1'b0;
        cyc(3);
        check(state === MPS_SLEEP && link.power_good_output === 1'b0 && asleep === 1'b1, "sleep");
        force_req = 1'b1;
        cyc(1);
        force_req = 1'b0;
        cyc(5);
        check(state === MPS_SLEEP, "force ignored in sleep");
        wake_req = 1'b1;
        cyc(1);
        wake_req = 1'b0;
        cyc(20);
        check(state === MPS_SLEEP && wake_busy === 1'b1, "wake not yet long enough");
        wait_state(MPS_UP, 40);
        check(link.power_good_output === 1'b1 && wake_busy === 1'b0, "woken");
        wait_state(MPS_READY, PG_CYC + 5);
        psm_exp = 1'b1;
        cyc(1);
        psm_exp = 1'b0;
        cyc(5);
        sched_wake = 1'b1;
        cyc(1);
        sched_wake = 1'b0;
        wait_state(MPS_UP, 20);
        check(state === MPS_UP, "scheduled wake");
        psm_en = 1'b0;
        psm_prep = 1'b0;
        usb_pres = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(16);
        rstn_in = 1'b1;
        cyc(2);
        power_up();
        t_spi();
        t_turn_off();
        t_fast_pd();
        t_force();
        t_psm();
        rstn_in = 1'b0;
        cyc(2);
        check(state === MPS_OFF && link.power_good_output === 1'b0 && link.spi_cs_n === 1'b1 && core_reset === 1'b1, "reset");
        rstn_in = 1'b1;
        give_verdict();
    end

    // the whole run needs under 2000 cycles, so this only fires on a hang
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        $display("CHECK FAILED at %0t ns: watchdog", $time);
        give_verdict();
    end
endmodule
